// ### inc/esg_pkg.sv
// Contract
// - host sets the write latch before any write
// - latch commands act only at deselect
// - latch clears on reset, clear command, write completion
// - status read always allowed, byte repeats
// - busy flag is one during write cycles
// - latch at zero rejects every write
// - block guard bits refuse writes to region
// - lock bit plus low pin freezes status
// - status write ends exactly after data byte
// - status write deselect starts timed cycle
// - new guard bits apply after cycle completes
// - bits six to four read zero
// - lock at zero allows status write anyway
// - lock at one needs guard pin high
// - hardware guard entered in either order
// - only guard pin high leaves hardware guard
// - guarded regions refuse writes in both modes
// - lock bit delivered as zero
// - opcode byte values for the six commands
// - unknown opcode ignores rest of frame
// - guard encoding selects quarter, half, whole array
// - writes need whole multiple of eight clocks
package esg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// opcodes
	localparam logic [7:0] ESG_OP_NONE         = 8'h00;
	localparam logic [7:0] ESG_OP_LATCH_SET    = 8'h06;
	localparam logic [7:0] ESG_OP_LATCH_CLEAR  = 8'h04;
	localparam logic [7:0] ESG_OP_STATUS_READ  = 8'h05;
	localparam logic [7:0] ESG_OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] ESG_OP_MEM_READ     = 8'h03;
	localparam logic [7:0] ESG_OP_MEM_WRITE    = 8'h02;

	////////////////////////////////////////////////////////////////////////////
	// status register fields
	localparam int ESG_BIT_BUSY   = 0;
	localparam int ESG_BIT_LATCH  = 1;
	localparam int ESG_BIT_BG_LO  = 2;
	localparam int ESG_BIT_BG_HI  = 3;
	localparam int ESG_BIT_LOCK   = 7;

	localparam logic       ESG_RST_LOCK = 1'b0;
	localparam logic [1:0] ESG_RST_BG   = 2'b00;

	////////////////////////////////////////////////////////////////////////////
	// array regions, 15-bit word of the 16-bit address
	localparam logic [14:0] ESG_QUARTER_BASE = 15'h6000;
	localparam logic [14:0] ESG_HALF_BASE    = 15'h4000;

	////////////////////////////////////////////////////////////////////////////
	// frame lengths in bytes
	localparam logic [2:0] ESG_STATUS_WRITE_CMD_BYTES      = 3'h2;
	localparam logic [2:0] ESG_MEM_WR_MIN_BYTE = 3'h4;
	localparam logic [2:0] ESG_BYTE_CNT_MAX    = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int ESG_CORE_CLK_NS        = 5;
	localparam int ESG_SELF_TIMED_CYCLE_NS = 4000000;
	localparam int ESG_CYCLE_COUNT        =
		(ESG_SELF_TIMED_CYCLE_NS + ESG_CORE_CLK_NS - 1) / ESG_CORE_CLK_NS;
	localparam int ESG_TIMER_W            = 20;

	typedef enum logic [1:0] {
		ESG_IDLE,
		ESG_STATUS_CYC,
		ESG_MEM_CYC
	} esg_state_e;

	function automatic logic esg_op_valid(input logic [7:0] op);
		case (op)
			ESG_OP_LATCH_SET, ESG_OP_LATCH_CLEAR, ESG_OP_STATUS_READ,
			ESG_OP_STATUS_WRITE, ESG_OP_MEM_READ, ESG_OP_MEM_WRITE: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

endpackage

// ### inc/esg_frame_if.sv
`timescale 1ns/1ps
interface esg_frame_if;
	logic       link_rst_n;
	logic [7:0] opcode;
	logic [7:0] byte1;
	logic [7:0] byte2;
	logic [2:0] byte_cnt;
	logic [2:0] bit_in_byte;
	logic       frame_tog;
	logic [7:0] status_byte;

	modport front (
		input  link_rst_n,
		input  status_byte,
		output opcode,
		output byte1,
		output byte2,
		output byte_cnt,
		output bit_in_byte,
		output frame_tog
	);

	modport core (
		output link_rst_n,
		output status_byte,
		input  opcode,
		input  byte1,
		input  byte2,
		input  byte_cnt,
		input  bit_in_byte,
		input  frame_tog
	);
endinterface

// ### rtl/esg_spi_front.sv
`timescale 1ns/1ps
module esg_spi_front (
	// link pins
	input  wire logic spi_sclk,
	input  wire logic spi_cs_n,
	input  wire logic spi_mosi,
	output logic      spi_miso,
	output logic      spi_miso_oe,
	// frame fields toward the core
	esg_frame_if.front fr
);
	import esg_pkg::*;

	logic       fresh;
	logic [6:0] shift;
	logic [7:0] st_meta;
	logic [7:0] st_sync;
	logic [7:0] st_shadow;
	logic [7:0] next_byte;
	logic [2:0] bit_now;
	logic       byte_done;

	////////////////////////////////////////////////////////////////////////////
	// first edge of a frame; the link clock may stand still while deselected
	// link reset too: a select level already high at power-up gives no edge
	always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge fr.link_rst_n) begin
		if (!fr.link_rst_n) begin
			fresh <= 1'b1;
		end else if (spi_cs_n) begin
			fresh <= 1'b1;
		end else begin
			fresh <= 1'b0;
		end
	end

	assign bit_now   = fresh ? 3'h0 : fr.bit_in_byte;
	assign next_byte = {shift, spi_mosi};
	assign byte_done = (bit_now == 3'h7);

	always_ff @(posedge spi_sclk or negedge fr.link_rst_n) begin
		if (!fr.link_rst_n) begin
			shift          <= 7'h00;
			fr.bit_in_byte <= 3'h0;
			fr.byte_cnt    <= 3'h0;
			fr.opcode      <= ESG_OP_NONE;
			fr.byte1       <= 8'h00;
			fr.byte2       <= 8'h00;
			fr.frame_tog   <= 1'b0;
		end else begin
			shift          <= next_byte[6:0];
			fr.bit_in_byte <= bit_now + 3'h1;
			if (fresh) begin
				fr.frame_tog <= ~fr.frame_tog;
				fr.byte_cnt  <= 3'h0;
				fr.opcode    <= ESG_OP_NONE;
			end else if (byte_done && fr.byte_cnt != ESG_BYTE_CNT_MAX) begin
				fr.byte_cnt <= fr.byte_cnt + 3'h1;
			end
			// after an unknown opcode nothing more is captured
			if (!fresh && byte_done) begin
				if (fr.byte_cnt == 3'h0) begin
					fr.opcode <= next_byte;
				end else if (esg_op_valid(fr.opcode) && fr.byte_cnt == 3'h1) begin
					fr.byte1 <= next_byte;
				end else if (esg_op_valid(fr.opcode) && fr.byte_cnt == 3'h2) begin
					fr.byte2 <= next_byte;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status bits cross in independently; refreshed by the opcode byte's edges
	always_ff @(posedge spi_sclk or negedge fr.link_rst_n) begin
		if (!fr.link_rst_n) begin
			st_meta <= 8'h00;
			st_sync <= 8'h00;
		end else begin
			st_meta <= fr.status_byte;
			st_sync <= st_meta;
		end
	end

	// status byte shifted on falling edges, repeated while selected
	always_ff @(negedge spi_sclk or posedge spi_cs_n or negedge fr.link_rst_n) begin
		if (!fr.link_rst_n) begin
			spi_miso    <= 1'b0;
			spi_miso_oe <= 1'b0;
			st_shadow   <= 8'h00;
		end else if (spi_cs_n) begin
			spi_miso    <= 1'b0;
			spi_miso_oe <= 1'b0;
			st_shadow   <= 8'h00;
		end else if (fr.opcode == ESG_OP_STATUS_READ && fr.byte_cnt != 3'h0) begin
			spi_miso_oe <= 1'b1;
			if (fr.bit_in_byte == 3'h0) begin
				st_shadow <= st_sync;
				spi_miso  <= st_sync[7];
			end else begin
				spi_miso <= st_shadow[~fr.bit_in_byte];
			end
		end else begin
			spi_miso    <= 1'b0;
			spi_miso_oe <= 1'b0;
		end
	end

endmodule

// ### rtl/esg_status_guard.sv
`timescale 1ns/1ps
module esg_status_guard #(
	parameter int CYCLE_COUNT = esg_pkg::ESG_CYCLE_COUNT
) (
	// core clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// serial link
	input  wire logic        spi_sclk,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	output logic             spi_miso_oe,
	// write guard pin, low guards
	input  wire logic        write_guard_n,
	// array write request
	output logic             mem_write_go,
	output logic [15:0]      mem_write_addr,
	// status view
	output logic             busy_cycle_flag,
	output logic             write_latch_flag,
	output logic             block_guard_hi,
	output logic             block_guard_lo,
	output logic             status_lock_bit,
	output logic             hardware_guard_mode,
	output logic [7:0]       status_register,
	// refused write frames
	output logic             write_refused
);
	import esg_pkg::*;

	esg_frame_if fr ();

	logic                   cs_meta;
	logic                   cs_sync;
	logic                   cs_prev;
	logic                   wp_meta;
	logic                   wp_sync;
	logic                   tog_meta;
	logic                   tog_sync;
	logic                   tog_done;
	logic                   frame_end;
	logic                   on_boundary;
	logic                   hw_guard;
	logic                   idle;
	logic                   take_set;
	logic                   take_clr;
	logic                   try_sw;
	logic                   try_mw;
	logic                   take_sw;
	logic                   take_mw;
	logic                   cyc_done;
	logic [15:0]            frame_addr;
	logic                   pend_lock;
	logic [1:0]             pend_bg;
	logic [ESG_TIMER_W-1:0] timer;
	esg_state_e             state;
	esg_state_e             next_state;

	////////////////////////////////////////////////////////////////////////////
	// link side
	esg_spi_front u_front (
		.spi_sclk    (spi_sclk),
		.spi_cs_n    (spi_cs_n),
		.spi_mosi    (spi_mosi),
		.spi_miso    (spi_miso),
		.spi_miso_oe (spi_miso_oe),
		.fr          (fr.front)
	);

	// registered so the link side sees a glitch-free async reset
	always_ff @(posedge core_clk) begin
		fr.link_rst_n <= resetn;
	end

	////////////////////////////////////////////////////////////////////////////
	// synchronisers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_prev  <= 1'b1;
			wp_meta  <= 1'b1;
			wp_sync  <= 1'b1;
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
		end else begin
			cs_meta  <= spi_cs_n;
			cs_sync  <= cs_meta;
			cs_prev  <= cs_sync;
			wp_meta  <= write_guard_n;
			wp_sync  <= wp_meta;
			tog_meta <= fr.frame_tog;
			tog_sync <= tog_meta;
		end
	end

	// frame fields are still because the link clock stops while deselected
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tog_done <= 1'b0;
		end else if (cs_sync && !cs_prev) begin
			tog_done <= tog_sync;
		end
	end

	assign frame_end   = cs_sync && !cs_prev && (tog_sync != tog_done);
	assign on_boundary = (fr.bit_in_byte == 3'h0);
	assign frame_addr  = {fr.byte1, fr.byte2};
	assign idle        = (state == ESG_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// guard decode
	function automatic logic guarded(input logic [15:0] a, input logic [1:0] bg);
		case (bg)
			2'b01: begin
				return a[14:0] >= ESG_QUARTER_BASE;
			end
			2'b10: begin
				return a[14:0] >= ESG_HALF_BASE;
			end
			2'b11: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	// either order of lock and pin; only the pin going high releases
	assign hw_guard = status_lock_bit && !wp_sync;

	////////////////////////////////////////////////////////////////////////////
	// command acceptance
	// latch commands during a cycle are dropped so completion clears cleanly
	assign take_set = frame_end && fr.opcode == ESG_OP_LATCH_SET && fr.byte_cnt != 3'h0
		&& idle;
	assign take_clr = frame_end && fr.opcode == ESG_OP_LATCH_CLEAR && fr.byte_cnt != 3'h0
		&& idle;

	// exactly opcode plus one byte, deselect before the next rising edge
	assign try_sw = frame_end && fr.opcode == ESG_OP_STATUS_WRITE
		&& fr.byte_cnt == ESG_STATUS_WRITE_CMD_BYTES && on_boundary;
	assign try_mw = frame_end && fr.opcode == ESG_OP_MEM_WRITE
		&& fr.byte_cnt >= ESG_MEM_WR_MIN_BYTE && on_boundary;

	// lock at zero ignores the pin, lock at one needs it high
	assign take_sw = try_sw && write_latch_flag && idle && !hw_guard;
	assign take_mw = try_mw && write_latch_flag && idle
		&& !guarded(frame_addr, {block_guard_hi, block_guard_lo});

	////////////////////////////////////////////////////////////////////////////
	// self-timed cycle
	always_comb begin
		next_state = state;
		case (state)
			ESG_IDLE: begin
				if (take_sw) begin
					next_state = ESG_STATUS_CYC;
				end else if (take_mw) begin
					next_state = ESG_MEM_CYC;
				end
			end
			ESG_STATUS_CYC, ESG_MEM_CYC: begin
				if (timer == '0) begin
					next_state = ESG_IDLE;
				end
			end
			default: begin
				next_state = ESG_IDLE;
			end
		endcase
	end

	assign cyc_done = !idle && timer == '0;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state           <= ESG_IDLE;
			busy_cycle_flag <= 1'b0;
		end else begin
			state           <= next_state;
			busy_cycle_flag <= (next_state != ESG_IDLE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			timer <= '0;
		end else if (take_sw || take_mw) begin
			timer <= ESG_TIMER_W'(CYCLE_COUNT - 1);
		end else if (timer != '0) begin
			timer <= timer - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write latch
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			write_latch_flag <= 1'b0;
		end else if (take_clr || cyc_done) begin
			write_latch_flag <= 1'b0;
		end else if (take_set) begin
			write_latch_flag <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// non-volatile bits; reset stands for the load of the stored values
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pend_lock <= ESG_RST_LOCK;
			pend_bg   <= ESG_RST_BG;
		end else if (take_sw) begin
			// other data bits are dropped
			pend_lock <= fr.byte1[ESG_BIT_LOCK];
			pend_bg   <= {fr.byte1[ESG_BIT_BG_HI], fr.byte1[ESG_BIT_BG_LO]};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			status_lock_bit <= ESG_RST_LOCK;
			block_guard_hi  <= ESG_RST_BG[1];
			block_guard_lo  <= ESG_RST_BG[0];
		end else if (cyc_done && state == ESG_STATUS_CYC) begin
			status_lock_bit <= pend_lock;
			block_guard_hi  <= pend_bg[1];
			block_guard_lo  <= pend_bg[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			status_register     <= 8'h00;
			hardware_guard_mode <= 1'b0;
			mem_write_go        <= 1'b0;
			mem_write_addr      <= 16'h0000;
			write_refused       <= 1'b0;
		end else begin
			status_register                <= 8'h00;
			status_register[ESG_BIT_BUSY]  <= busy_cycle_flag;
			status_register[ESG_BIT_LATCH] <= write_latch_flag;
			status_register[ESG_BIT_BG_LO] <= block_guard_lo;
			status_register[ESG_BIT_BG_HI] <= block_guard_hi;
			status_register[ESG_BIT_LOCK]  <= status_lock_bit;
			hardware_guard_mode            <= hw_guard;
			mem_write_go                   <= take_mw;
			write_refused                  <= (frame_end && !take_sw && !take_mw
				&& (fr.opcode == ESG_OP_STATUS_WRITE || fr.opcode == ESG_OP_MEM_WRITE));
			if (take_mw) begin
				mem_write_addr <= frame_addr;
			end
		end
	end

	assign fr.status_byte = status_register;

endmodule

// ### tb/esg_status_guard_chk.sv
`timescale 1ns/1ps
module esg_status_guard_chk #(
	parameter int CYCLE_COUNT = esg_pkg::ESG_CYCLE_COUNT
) (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       resetn,
	// pins
	input wire logic       spi_cs_n,
	input wire logic       spi_miso_oe,
	input wire logic       write_guard_n,
	// status view
	input wire logic       busy_cycle_flag,
	input wire logic       write_latch_flag,
	input wire logic       block_guard_hi,
	input wire logic       block_guard_lo,
	input wire logic       status_lock_bit,
	input wire logic       hardware_guard_mode,
	input wire logic [7:0] status_register,
	input wire logic       write_refused
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic [19:0] busy_len;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			busy_len <= 20'h0;
		end else begin
			busy_len <= busy_cycle_flag ? busy_len + 20'h1 : 20'h0;
		end
	end
	a_high_bits_zero: assert property (status_register[6:4] == 3'h0)
		else $error("status bits 6..4 not zero");
	a_status_layout: assert property (status_register == $past({status_lock_bit, 3'h0,
		block_guard_hi, block_guard_lo, write_latch_flag, busy_cycle_flag}))
		else $error("status byte does not match its flags");
	a_busy_length: assert property ($fell(busy_cycle_flag) |->
		busy_len >= CYCLE_COUNT - 1 && busy_len <= CYCLE_COUNT + 1)
		else $error("self-timed cycle length wrong");
	a_latch_clear_end: assert property ($fell(busy_cycle_flag) |-> !write_latch_flag)
		else $error("latch still set after cycle");
	a_guard_moves_end: assert property (($changed(status_lock_bit) ||
		$changed({block_guard_hi, block_guard_lo})) |-> $fell(busy_cycle_flag))
		else $error("guard bits changed outside cycle end");
	a_latch_set_idle: assert property ($rose(write_latch_flag) |->
		$past(spi_cs_n, 2) && !busy_cycle_flag)
		else $error("latch set while selected or busy");
	a_pin_high_frees: assert property (write_guard_n [*4] |=> !hardware_guard_mode)
		else $error("guard mode kept with pin high");
	a_hw_bits_frozen: assert property (hardware_guard_mode |=>
		$stable({status_lock_bit, block_guard_hi, block_guard_lo}))
		else $error("guard bits changed in guard mode");
	a_refuse_no_cycle: assert property (write_refused && !busy_cycle_flag |=>
		!busy_cycle_flag)
		else $error("refused write started a cycle");
	a_oe_selected: assert property (spi_miso_oe |-> !spi_cs_n)
		else $error("output driven while deselected");
	c_refused: cover property (write_refused);
	c_hw_mode: cover property ($rose(hardware_guard_mode));
	c_cycle_done: cover property ($fell(busy_cycle_flag));
endmodule

// ### tb/esg_host_model.sv
`timescale 1ns/1ps
module esg_host_model (
	// link pins
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input  wire logic spi_miso
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// clock stands still outside frames; whole bytes are the caller's duty
	task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] rd);
		spi_cs_n = 1'b0;
		#32;
		for (int i = 0; i < n; i++) begin
			spi_mosi = w[31-i];
			#32 spi_sclk = 1'b1;
			rd = {rd[6:0], spi_miso};
			#32 spi_sclk = 1'b0;
		end
		#16 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		// gap lets the core read the fields before the next frame
		#40;
	endtask
endmodule

// ### tb/esg_status_guard_tb_top.sv
`timescale 1ns/1ps
module esg_status_guard_tb_top;
	import esg_pkg::*;
	localparam int CYC = 400;
	logic core_clk = 1'b0, resetn = 1'b0, write_guard_n = 1'b1;
	logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, mem_write_go;
	logic busy_cycle_flag, write_latch_flag, block_guard_hi, block_guard_lo;
	logic status_lock_bit, hardware_guard_mode, write_refused, oe_seen;
	logic [15:0] mem_write_addr;
	logic [7:0] status_register, rd;
	int errors = 0, checks = 0, ref_cnt = 0, go_cnt = 0, r0;
	always #2.5 core_clk = ~core_clk;
	esg_status_guard #(.CYCLE_COUNT(CYC)) u_esg_status_guard (.core_clk(core_clk),
		.resetn(resetn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .write_guard_n(write_guard_n),
		.mem_write_go(mem_write_go), .mem_write_addr(mem_write_addr),
		.busy_cycle_flag(busy_cycle_flag), .write_latch_flag(write_latch_flag),
		.block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo),
		.status_lock_bit(status_lock_bit), .hardware_guard_mode(hardware_guard_mode),
		.status_register(status_register), .write_refused(write_refused));
	esg_host_model u_esg_host_model (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso));
	always @(posedge core_clk) begin
		if (write_refused === 1'b1) ref_cnt++;
		if (mem_write_go === 1'b1) go_cnt++;
		if (spi_miso_oe === 1'b1) oe_seen = 1'b1;
	end
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic x(input logic [31:0] w, input int n);
		u_esg_host_model.xfer(w, n, rd);
	endtask
	task automatic cmd(input logic [7:0] op);
		x({op, 24'h0}, 8);
	endtask
	// polls busy through status reads, as a host on the link would
	task automatic wait_idle();
		int n;
		n = 0;
		rd = 8'h01;
		while (rd[0] !== 1'b0 && n < 40) begin
			x({ESG_OP_STATUS_READ, 24'h0}, 16);
			n++;
		end
		chk_flag(n < 40, 1'b1);
		chk_flag(busy_cycle_flag, 1'b0);
		repeat (3) @(negedge core_clk);
	endtask
	task automatic status_write_cmd(input logic [7:0] d);
		cmd(ESG_OP_LATCH_SET);
		x({ESG_OP_STATUS_WRITE, d, 16'h0}, 16);
	endtask
	task automatic pin(input logic v);
		@(negedge core_clk);
		write_guard_n = v;
		repeat (6) @(negedge core_clk);
	endtask
	task automatic test_latch();
		chk_byte(status_register, 8'h00);
		cmd(ESG_OP_LATCH_SET);
		chk_flag(write_latch_flag, 1'b1);
		oe_seen = 1'b0;
		x({ESG_OP_STATUS_READ, 24'h0}, 24);
		chk_byte(rd, 8'h02);
		chk_flag(oe_seen, 1'b1);
		cmd(ESG_OP_LATCH_CLEAR);
		chk_flag(write_latch_flag, 1'b0);
		$display("test latch done");
	endtask
	task automatic test_refuse();
		r0 = ref_cnt;
		x({ESG_OP_STATUS_WRITE, 24'h8C0000}, 16);
		chk_flag(ref_cnt == r0 + 1, 1'b1);
		cmd(ESG_OP_LATCH_SET);
		x({ESG_OP_STATUS_WRITE, 24'h8C0000}, 15);
		x({ESG_OP_STATUS_WRITE, 24'h8C0000}, 17);
		chk_flag(ref_cnt == r0 + 3, 1'b1);
		oe_seen = 1'b0;
		x(32'hAB05_0000, 24);
		chk_flag(oe_seen, 1'b0);
		x({ESG_OP_MEM_READ, 24'h0}, 32);
		chk_flag(ref_cnt == r0 + 3 && busy_cycle_flag === 1'b0, 1'b1);
		chk_byte(status_register, 8'h02);
		cmd(ESG_OP_LATCH_CLEAR);
		$display("test refuse done");
	endtask
	task automatic test_write();
		status_write_cmd(8'hF7);
		x({ESG_OP_STATUS_READ, 24'h0}, 24);
		chk_byte(rd, 8'h03);
		wait_idle();
		chk_byte(status_register, 8'h84);
		$display("test write done");
	endtask
	task automatic test_guard();
		pin(1'b0);
		chk_flag(hardware_guard_mode, 1'b1);
		r0 = ref_cnt;
		status_write_cmd(8'h00);
		chk_flag(ref_cnt == r0 + 1, 1'b1);
		chk_byte(status_register, 8'h86);
		cmd(ESG_OP_LATCH_CLEAR);
		chk_flag(hardware_guard_mode, 1'b1);
		pin(1'b1);
		chk_flag(hardware_guard_mode, 1'b0);
		status_write_cmd(8'h88);
		wait_idle();
		chk_byte(status_register, 8'h88);
		status_write_cmd(8'h00);
		wait_idle();
		pin(1'b0);
		status_write_cmd(8'h80);
		wait_idle();
		chk_byte(status_register, 8'h80);
		chk_flag(hardware_guard_mode, 1'b1);
		pin(1'b1);
		$display("test guard done");
	endtask
	task automatic test_regions();
		logic [15:0] a;
		logic g;
		logic [15:0] al [4] = '{16'h3FFF, 16'h4000, 16'h5FFF, 16'hE000};
		for (int b = 0; b < 4; b++) begin
			status_write_cmd({4'h0, b[1:0], 2'h0});
			wait_idle();
			for (int i = 0; i < 4; i++) begin
				a = al[i];
				g = b == 3 || (b == 2 && a[14:0] >= ESG_HALF_BASE) ||
					(b == 1 && a[14:0] >= ESG_QUARTER_BASE);
				r0 = go_cnt;
				cmd(ESG_OP_LATCH_SET);
				x({ESG_OP_MEM_WRITE, a, 8'h5A}, 32);
				chk_flag(go_cnt == r0 + 1, !g);
				if (!g) chk_byte(mem_write_addr[7:0], a[7:0]);
				if (!g) chk_byte(mem_write_addr[15:8], a[15:8]);
				wait_idle();
				chk_flag(write_latch_flag, g);
			end
		end
		$display("test regions done");
	endtask
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// tests need about 150 us; stop well short of 100k cycles
	initial begin
		#400000;
		errors++;
		summarize();
	end
	initial begin
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		test_latch();
		test_refuse();
		test_write();
		test_guard();
		test_regions();
		summarize();
	end
endmodule
bind esg_status_guard esg_status_guard_chk #(.CYCLE_COUNT(CYCLE_COUNT)) u_esg_status_guard_chk (
	.core_clk(core_clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
	.write_guard_n(write_guard_n), .busy_cycle_flag(busy_cycle_flag),
	.write_latch_flag(write_latch_flag), .block_guard_hi(block_guard_hi),
	.block_guard_lo(block_guard_lo), .status_lock_bit(status_lock_bit),
	.hardware_guard_mode(hardware_guard_mode), .status_register(status_register),
	.write_refused(write_refused));
